/* src/simd_fp_exc_pkg.sv */
// Constants and types shared by the SIMD floating-point exception unit
package simd_fp_exc_pkg;

	// Exception classes, also the flag bit order (lower index wins priority)
	localparam int NUM_CLASSES = 6;
	localparam int CLS_INVALID = 0;
	localparam int CLS_SUBNORMAL = 1;
	localparam int CLS_ZERO_DIVIDE = 2;
	localparam int CLS_OVERFLOW = 3;
	localparam int CLS_UNDERFLOW = 4;
	localparam int CLS_PRECISION = 5;

	// Control/status register layout
	localparam int FLAG_LSB = 0;
	localparam int MASK_LSB = 7;
	localparam logic [5:0] FLAGS_RESET = 6'h00;
	localparam logic [5:0] MASKS_RESET = 6'h3F;

	// System control register four
	localparam int OS_OK_BIT = 10;
	localparam logic OS_OK_RESET = 1'b0;

	// Register offsets (byte addresses)
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFF_CTL_STATUS = 8'h00;
	localparam logic [7:0] OFF_SYS_CTL = 8'h04;
	localparam logic [7:0] OFF_IRQ_STATUS = 8'h08;
	localparam logic [7:0] OFF_IRQ_CLEAR = 8'h0C;
	localparam logic [7:0] OFF_IRQ_ENABLE = 8'h10;
	localparam logic [7:0] OFF_LAST_TRAP = 8'h14;

	// Interrupt event bits
	localparam int IRQ_BITS = 3;
	localparam int IRQ_SIMD_TRAP = 0;
	localparam int IRQ_ILLEGAL_TRAP = 1;
	localparam int IRQ_NON_NUMERIC = 2;
	localparam logic [2:0] IRQ_EN_RESET = 3'h0;

	// Last-trap register fields
	localparam int LAST_VALID_BIT = 31;
	localparam int LAST_ILLEGAL_BIT = 30;

	typedef enum logic [1:0] {
		KIND_OTHER,
		KIND_FP,
		KIND_PACKED_INT,
		KIND_TRUNC_STORE
	} instr_kind_t;

	typedef enum logic {
		BUS_IDLE,
		BUS_ANSWER
	} bus_state_t;

endpackage : simd_fp_exc_pkg

/* src/exc_class_pick.sv */
// Fixed-priority pick of one exception class among detected ones
`timescale 1ns/1ps
module exc_class_pick #(
	parameter int NUM = 6
) (
	// Detected classes
	input wire logic [NUM-1:0] cond,
	// Chosen class
	output logic any,
	output logic [2:0] cls
);

	initial begin
		if (NUM < 1 || NUM > 8) begin
			$error("exc_class_pick: NUM must be 1..8");
		end
	end

	// Lowest index has highest priority, so scan from the top down
	always_comb begin
		any = 1'b0;
		cls = 3'h0;
		for (int i = NUM - 1; i >= 0; i--) begin
			if (cond[i]) begin
				any = 1'b1;
				cls = 3'(i);
			end
		end
	end

endmodule : exc_class_pick

/* src/simd_fp_exception_unit.sv */
// SIMD floating-point exception unit with Avalon-MM register access
`timescale 1ns/1ps

// Overview of operation
// - Six floating-point exception classes are recognised
// - Only floating-point operations raise numeric exceptions
// - Exceptions are precise, reported at completion
// - Each class has one flag and mask
// - Masks writable by load/restore; all readable
// - Unmasked exception with OS bit raises trap
// - OS bit clear raises illegal-opcode trap instead
// - Non-numeric exceptions use the ordinary paths
// - Truncating integer store raises only legacy exceptions
// - Invalid flag bit 0, mask bit 7
// - Subnormal flag bit 1, mask bit 8
// - Unmasked invalid keeps operands, enters handler
// - Masked invalid writes the default response
module simd_fp_exception_unit
	import simd_fp_exc_pkg::*;
#(
	parameter int NUM_CLS = simd_fp_exc_pkg::NUM_CLASSES,
	parameter int VEC_W = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Avalon-MM slave
	input wire logic [simd_fp_exc_pkg::ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	// Instruction completion from the datapath
	input wire logic doneValid,
	input wire simd_fp_exc_pkg::instr_kind_t doneKind,
	input wire logic [NUM_CLS-1:0] doneCond,
	input wire logic doneNonNumeric,
	input wire logic [VEC_W-1:0] doneVector,
	// Control register instructions from the core
	input wire logic ctlLoad,
	input wire logic [31:0] ctlLoadData,
	output logic [31:0] ctlValue,
	// Trap dispatch
	output logic simdFpTrap,
	output logic illegalOpcodeTrap,
	output logic [2:0] trapClass,
	output logic nonNumericTrap,
	output logic [VEC_W-1:0] nonNumericVector,
	output logic keepOperands,
	output logic maskedInvalidFix,
	output logic [NUM_CLS-1:0] legacyFpuCond,
	// Interrupt
	output logic irq
);

	initial begin
		// Class pick and trap class field assume six classes
		if (NUM_CLS != NUM_CLASSES) begin
			$error("simd_fp_exception_unit: NUM_CLS must equal six");
		end
		if (VEC_W < 1 || VEC_W > 16) begin
			$error("simd_fp_exception_unit: VEC_W must be 1..16");
		end
		// Flags are written through lane 0, masks through lanes 0 and 1
		if (FLAG_LSB + NUM_CLS > MASK_LSB || FLAG_LSB + NUM_CLS > 8) begin
			$error("simd_fp_exception_unit: flag field must sit in lane 0 below the masks");
		end
		if (MASK_LSB < 1 || MASK_LSB + NUM_CLS > 16) begin
			$error("simd_fp_exception_unit: mask field must sit in lanes 0 and 1");
		end
		// The OS bit is written through lane 1 only
		if (OS_OK_BIT < 8 || OS_OK_BIT > 15) begin
			$error("simd_fp_exception_unit: OS bit must sit in lane 1");
		end
		// Interrupt enable and clear are written through lane 0
		if (IRQ_BITS > 8) begin
			$error("simd_fp_exception_unit: at most eight interrupt events");
		end
		if (IRQ_SIMD_TRAP >= IRQ_BITS || IRQ_ILLEGAL_TRAP >= IRQ_BITS ||
			IRQ_NON_NUMERIC >= IRQ_BITS) begin
			$error("simd_fp_exception_unit: interrupt event bit out of range");
		end
		// Last-trap class sits in bits 2:0
		if (LAST_ILLEGAL_BIT < 3 || LAST_VALID_BIT < 3 || LAST_VALID_BIT == LAST_ILLEGAL_BIT) begin
			$error("simd_fp_exception_unit: last-trap flag bits misplaced");
		end
		// Offsets up to the last-trap register need five address bits
		if (ADDR_W < 5) begin
			$error("simd_fp_exception_unit: ADDR_W too small for the register map");
		end
	end

	typedef struct packed {
		bus_state_t bus;
		logic waitReq;
		logic [31:0] rdata;
		logic [NUM_CLS-1:0] flags;
		logic [NUM_CLS-1:0] masks;
		logic osOk;
		logic [IRQ_BITS-1:0] irqStat;
		logic [IRQ_BITS-1:0] irqEn;
		logic irq;
		logic simdTrap;
		logic illegalTrap;
		logic [2:0] trapCls;
		logic nnTrap;
		logic [VEC_W-1:0] nnVec;
		logic keepOps;
		logic invFix;
		logic [NUM_CLS-1:0] legacy;
		logic lastValid;
		logic lastIllegal;
		logic [2:0] lastCls;
	} state_t;

	state_t s_q;
	state_t s_d;

	// Per-byte write mask from byteenable
	logic [31:0] beMask;
	// Numeric conditions this completion may raise
	logic [NUM_CLS-1:0] fpCond;
	logic [NUM_CLS-1:0] unmaskedCond;
	logic pickAny;
	logic [2:0] pickCls;
	logic busTake;
	logic busWrite;
	logic [31:0] csrView;
	logic [31:0] sysView;
	logic [31:0] lastView;
	logic [31:0] rdMux;
	// Completion decodes
	logic fpDone;
	logic truncDone;
	logic nnDone;
	// Interrupt bits cleared by this write
	logic [IRQ_BITS-1:0] clrBits;

	generate
		for (genvar b = 0; b < 4; b++) begin : g_be
			assign beMask[8*b +: 8] = {8{byteenable[b]}};
		end
	endgenerate

	// Only floating-point completions feed the numeric path
	assign fpDone = doneValid && doneKind == KIND_FP;
	assign truncDone = doneValid && doneKind == KIND_TRUNC_STORE;
	assign nnDone = doneValid && doneNonNumeric;

	always_comb begin
		fpCond = '0;
		if (fpDone) begin
			fpCond = doneCond;
		end
	end

	assign unmaskedCond = fpCond & ~s_q.masks;

	exc_class_pick #(
		.NUM(NUM_CLS)
	) u_pick (
		.cond(unmaskedCond),
		.any(pickAny),
		.cls(pickCls)
	);

	// Register views; unused bits read as zero
	always_comb begin
		csrView = 32'h0000_0000;
		csrView[FLAG_LSB +: NUM_CLS] = s_q.flags;
		csrView[MASK_LSB +: NUM_CLS] = s_q.masks;
		sysView = 32'h0000_0000;
		sysView[OS_OK_BIT] = s_q.osOk;
		lastView = 32'h0000_0000;
		lastView[LAST_VALID_BIT] = s_q.lastValid;
		lastView[LAST_ILLEGAL_BIT] = s_q.lastIllegal;
		lastView[2:0] = s_q.lastCls;
	end

	// Read mux; unmapped offsets and the clear register read zero
	always_comb begin
		unique case (address)
			OFF_CTL_STATUS: rdMux = csrView;
			OFF_SYS_CTL: rdMux = sysView;
			OFF_IRQ_STATUS: rdMux = 32'(s_q.irqStat);
			OFF_IRQ_ENABLE: rdMux = 32'(s_q.irqEn);
			OFF_LAST_TRAP: rdMux = lastView;
			default: rdMux = 32'h0000_0000;
		endcase
	end

	// The access completes at the edge where waitrequest is seen low
	assign busTake = (read || write) && !s_q.waitReq;
	assign busWrite = write && !s_q.waitReq;
	// Write-one-to-clear, only through an enabled lane 0
	assign clrBits = writedata[IRQ_BITS-1:0] & beMask[IRQ_BITS-1:0];

	always_comb begin
		s_d = s_q;
		s_d.simdTrap = 1'b0;
		s_d.illegalTrap = 1'b0;
		s_d.nnTrap = 1'b0;
		s_d.keepOps = 1'b0;
		s_d.invFix = 1'b0;
		s_d.legacy = '0;

		// Bus handshake: one wait cycle, then the answer
		unique case (s_q.bus)
			BUS_IDLE: begin
				if (read || write) begin
					s_d.bus = BUS_ANSWER;
					s_d.waitReq = 1'b0;
					s_d.rdata = read ? rdMux : 32'h0000_0000;
				end
			end
			BUS_ANSWER: begin
				if (busTake) begin
					s_d.bus = BUS_IDLE;
					s_d.waitReq = 1'b1;
				end
			end
		endcase

		// Register writes from the bus
		if (busWrite) begin
			unique case (address)
				OFF_CTL_STATUS: begin
					if (byteenable[0]) begin
						s_d.flags = writedata[FLAG_LSB +: NUM_CLS];
					end
					if (byteenable[0] && byteenable[1]) begin
						s_d.masks = writedata[MASK_LSB +: NUM_CLS];
					end
				end
				OFF_SYS_CTL: begin
					if (byteenable[1]) begin
						s_d.osOk = writedata[OS_OK_BIT];
					end
				end
				OFF_IRQ_CLEAR: begin
					s_d.irqStat = s_q.irqStat & ~clrBits;
				end
				OFF_IRQ_ENABLE: begin
					if (byteenable[0]) begin
						s_d.irqEn = writedata[IRQ_BITS-1:0];
					end
				end
				default: begin
				end
			endcase
		end

		// Load or full-state restore from the core overrides a bus write
		if (ctlLoad) begin
			s_d.flags = ctlLoadData[FLAG_LSB +: NUM_CLS];
			s_d.masks = ctlLoadData[MASK_LSB +: NUM_CLS];
		end

		// Detection sets flags whether masked or not; set beats overwrite
		s_d.flags = s_d.flags | fpCond;

		// Truncating integer store only forwards to the legacy unit
		if (truncDone) begin
			s_d.legacy = doneCond;
		end

		// Non-numeric faults pass through untouched
		if (nnDone) begin
			s_d.nnTrap = 1'b1;
			s_d.nnVec = doneVector;
			s_d.irqStat[IRQ_NON_NUMERIC] = 1'b1;
		end else if (pickAny) begin
			// Reported in the cycle after completion, never deferred
			s_d.trapCls = pickCls;
			s_d.lastValid = 1'b1;
			s_d.lastCls = pickCls;
			if (s_q.osOk) begin
				s_d.simdTrap = 1'b1;
				s_d.lastIllegal = 1'b0;
				s_d.irqStat[IRQ_SIMD_TRAP] = 1'b1;
			end else begin
				s_d.illegalTrap = 1'b1;
				s_d.lastIllegal = 1'b1;
				s_d.irqStat[IRQ_ILLEGAL_TRAP] = 1'b1;
			end
			s_d.keepOps = 1'b1;
		end

		// Masked invalid: destination takes the default result
		if (fpCond[CLS_INVALID] && s_q.masks[CLS_INVALID] && !pickAny) begin
			s_d.invFix = 1'b1;
		end

		s_d.irq = |(s_d.irqStat & s_d.irqEn);
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_q.bus <= BUS_IDLE;
			s_q.waitReq <= 1'b1;
			s_q.rdata <= 32'h0000_0000;
			s_q.flags <= FLAGS_RESET;
			s_q.masks <= MASKS_RESET;
			s_q.osOk <= OS_OK_RESET;
			s_q.irqStat <= '0;
			s_q.irqEn <= IRQ_EN_RESET;
			s_q.irq <= 1'b0;
			s_q.simdTrap <= 1'b0;
			s_q.illegalTrap <= 1'b0;
			s_q.trapCls <= 3'h0;
			s_q.nnTrap <= 1'b0;
			s_q.nnVec <= '0;
			s_q.keepOps <= 1'b0;
			s_q.invFix <= 1'b0;
			s_q.legacy <= '0;
			s_q.lastValid <= 1'b0;
			s_q.lastIllegal <= 1'b0;
			s_q.lastCls <= 3'h0;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs straight from the state register
	assign readdata = s_q.rdata;
	assign waitrequest = s_q.waitReq;
	assign ctlValue = csrView;
	assign simdFpTrap = s_q.simdTrap;
	assign illegalOpcodeTrap = s_q.illegalTrap;
	assign trapClass = s_q.trapCls;
	assign nonNumericTrap = s_q.nnTrap;
	assign nonNumericVector = s_q.nnVec;
	assign keepOperands = s_q.keepOps;
	assign maskedInvalidFix = s_q.invFix;
	assign legacyFpuCond = s_q.legacy;
	assign irq = s_q.irq;

endmodule : simd_fp_exception_unit

/* tb/simd_fp_exception_unit_asserts.sv */
// Assertion checker for the SIMD floating-point exception unit
`timescale 1ns/1ps
module simd_fp_exception_unit_asserts
	import simd_fp_exc_pkg::*;
#(
	parameter int NUM_CLS = 6,
	parameter int VEC_W = 8
) (
	// Clock, reset, bus
	input wire logic clk,
	input wire logic rst_n,
	input wire logic read,
	input wire logic write,
	input wire logic waitrequest,
	// Completion and control load
	input wire logic doneValid,
	input wire simd_fp_exc_pkg::instr_kind_t doneKind,
	input wire logic [NUM_CLS-1:0] doneCond,
	input wire logic doneNonNumeric,
	input wire logic [VEC_W-1:0] doneVector,
	input wire logic ctlLoad,
	input wire logic [31:0] ctlLoadData,
	input wire logic [31:0] ctlValue,
	// Trap outputs
	input wire logic simdFpTrap,
	input wire logic illegalOpcodeTrap,
	input wire logic [2:0] trapClass,
	input wire logic nonNumericTrap,
	input wire logic [VEC_W-1:0] nonNumericVector,
	input wire logic keepOperands,
	input wire logic maskedInvalidFix,
	input wire logic [NUM_CLS-1:0] legacyFpuCond
);
	logic fpDone;
	logic [NUM_CLS-1:0] unmasked;
	logic [2:0] lowCls;
	// Lowest unmasked index wins, so scan downward
	always_comb begin
		fpDone = doneValid && doneKind == KIND_FP && !doneNonNumeric;
		unmasked = doneCond & ~ctlValue[MASK_LSB+:NUM_CLS];
		lowCls = 3'h0;
		for (int i = NUM_CLS - 1; i >= 0; i--) begin
			if (unmasked[i]) begin
				lowCls = 3'(i);
			end
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	property p_bus;
		(read || write) && waitrequest |-> ##[1:2] !waitrequest;
	endproperty
	a_bus: assert property (p_bus) else $error("bus answer late");
	property p_load;
		ctlLoad |=> ctlValue[MASK_LSB+:NUM_CLS] == $past(ctlLoadData[MASK_LSB+:NUM_CLS]);
	endproperty
	a_load: assert property (p_load) else $error("mask load lost");
	property p_prio;
		fpDone && unmasked != 0 |=> (simdFpTrap ^ illegalOpcodeTrap) && trapClass == $past(lowCls);
	endproperty
	a_prio: assert property (p_prio) else $error("trap class wrong");
	property p_int;
		doneValid && doneKind != KIND_FP |=> !simdFpTrap && !illegalOpcodeTrap;
	endproperty
	a_int: assert property (p_int) else $error("non fp trapped");
	property p_sticky;
		doneValid && doneKind == KIND_FP |=> (ctlValue[5:0] & $past(doneCond)) == $past(doneCond);
	endproperty
	a_sticky: assert property (p_sticky) else $error("flag not set");
	property p_hold;
		!doneValid && !ctlLoad && !write |=> $stable(ctlValue[5:0]);
	endproperty
	a_hold: assert property (p_hold) else $error("flag moved");
	property p_keep;
		simdFpTrap || illegalOpcodeTrap |-> keepOperands && !maskedInvalidFix;
	endproperty
	a_keep: assert property (p_keep) else $error("operands not kept");
	property p_fix;
		fpDone && doneCond[0] && unmasked == 0 |=> maskedInvalidFix;
	endproperty
	a_fix: assert property (p_fix) else $error("masked invalid");
	property p_trunc;
		doneValid && doneKind == KIND_TRUNC_STORE |=> legacyFpuCond == $past(doneCond);
	endproperty
	a_trunc: assert property (p_trunc) else $error("legacy cond");
	property p_nn;
		doneValid && doneNonNumeric |=> nonNumericTrap && nonNumericVector == $past(doneVector);
	endproperty
	a_nn: assert property (p_nn) else $error("non numeric");
endmodule : simd_fp_exception_unit_asserts

bind simd_fp_exception_unit simd_fp_exception_unit_asserts #(.NUM_CLS(NUM_CLS), .VEC_W(VEC_W))
	u_simd_fp_exception_unit_asserts (.clk, .rst_n, .read, .write, .waitrequest, .doneValid,
	.doneKind, .doneCond, .doneNonNumeric, .doneVector, .ctlLoad, .ctlLoadData, .ctlValue,
	.simdFpTrap, .illegalOpcodeTrap, .trapClass, .nonNumericTrap, .nonNumericVector,
	.keepOperands, .maskedInvalidFix, .legacyFpuCond);

/* tb/simd_fp_exception_unit_tb.sv */
// Self-checking bench for the SIMD floating-point exception unit
`timescale 1ns/1ps
module simd_fp_exception_unit_tb;
	import simd_fp_exc_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [7:0] address = 8'h00;
	logic [31:0] writedata = 32'h0;
	logic [3:0] byteenable = 4'hF;
	logic doneValid = 1'b0;
	instr_kind_t doneKind = KIND_OTHER;
	logic [5:0] doneCond = 6'h00;
	logic doneNonNumeric = 1'b0;
	logic [7:0] doneVector = 8'h00;
	logic ctlLoad = 1'b0;
	logic [31:0] ctlLoadData = 32'h0;
	logic waitrequest, simdFpTrap, illegalOpcodeTrap, nonNumericTrap, keepOperands;
	logic maskedInvalidFix, irq;
	logic [31:0] readdata, ctlValue, rdData;
	logic [2:0] trapClass;
	logic [7:0] nonNumericVector;
	logic [5:0] legacyFpuCond;
	int errTotal = 0;
	int compares = 0;
	always #50 clk = ~clk;
	simd_fp_exception_unit u_simd_fp_exception_unit (.clk, .rst_n, .address, .read, .write,
		.writedata, .byteenable, .readdata, .waitrequest, .doneValid, .doneKind, .doneCond,
		.doneNonNumeric, .doneVector, .ctlLoad, .ctlLoadData, .ctlValue, .simdFpTrap,
		.illegalOpcodeTrap, .trapClass, .nonNumericTrap, .nonNumericVector, .keepOperands,
		.maskedInvalidFix, .legacyFpuCond, .irq);
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			errTotal++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// Request held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		read <= !wr;
		write <= wr;
		address <= a;
		writedata <= d;
		do @(posedge clk); while (waitrequest);
		rdData = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask : bus
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(rdData, e);
	endtask : rdc
	// One completion; trap pulses are looked at in the cycle they stand
	task automatic issue(input instr_kind_t k, input logic [5:0] c, input logic nn);
		@(posedge clk);
		doneValid <= 1'b1;
		doneKind <= k;
		doneCond <= c;
		doneNonNumeric <= nn;
		doneVector <= 8'h0D;
		@(posedge clk);
		doneValid <= 1'b0;
		#1;
	endtask : issue
	// Bits: simd, illegal, keep, fix, non-numeric, class
	task automatic trp(input logic [7:0] e);
		chk({24'h0, simdFpTrap, illegalOpcodeTrap, keepOperands, maskedInvalidFix,
			nonNumericTrap, trapClass}, {24'h0, e});
	endtask : trp
	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", compares, errTotal);
		if (errTotal == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : tally_and_finish
	initial begin
		#500000;
		errTotal++;
		tally_and_finish();
	end
	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		rdc(OFF_CTL_STATUS, 32'h1F80);
		rdc(OFF_SYS_CTL, 32'h0);
		bus(1'b1, OFF_CTL_STATUS, 32'h0);
		issue(KIND_FP, 6'h06, 1'b0);
		trp(8'h61);
		rdc(OFF_CTL_STATUS, 32'h06);
		rdc(OFF_LAST_TRAP, 32'hC000_0001);
		$display("test os clear done");
		bus(1'b1, OFF_SYS_CTL, 32'h400);
		issue(KIND_FP, 6'h30, 1'b0);
		trp(8'hA4);
		rdc(OFF_CTL_STATUS, 32'h36);
		$display("test os set done");
		bus(1'b1, OFF_CTL_STATUS, 32'h1F80);
		issue(KIND_FP, 6'h01, 1'b0);
		trp(8'h14);
		chk(ctlValue, 32'h1F81);
		issue(KIND_PACKED_INT, 6'h3F, 1'b0);
		trp(8'h04);
		issue(KIND_TRUNC_STORE, 6'h0A, 1'b0);
		chk({26'h0, legacyFpuCond}, 32'h0A);
		chk(ctlValue, 32'h1F81);
		issue(KIND_OTHER, 6'h00, 1'b1);
		trp(8'h0C);
		chk({24'h0, nonNumericVector}, 32'h0D);
		$display("test masked and kinds done");
		rdc(OFF_IRQ_STATUS, 32'h7);
		chk({31'h0, irq}, 32'h0);
		bus(1'b1, OFF_IRQ_ENABLE, 32'h1);
		rdc(OFF_IRQ_CLEAR, 32'h0);
		chk({31'h0, irq}, 32'h1);
		bus(1'b1, OFF_IRQ_CLEAR, 32'h1);
		rdc(OFF_IRQ_STATUS, 32'h6);
		chk({31'h0, irq}, 32'h0);
		rdc(8'h20, 32'h0);
		$display("test irq done");
		@(posedge clk);
		ctlLoad <= 1'b1;
		ctlLoadData <= 32'h0B15;
		@(posedge clk);
		ctlLoad <= 1'b0;
		#1;
		chk(ctlValue, 32'h0B15);
		issue(KIND_FP, 6'h0A, 1'b0);
		trp(8'hA3);
		rdc(OFF_CTL_STATUS, 32'h0B1F);
		rdc(OFF_LAST_TRAP, 32'h8000_0003);
		byteenable <= 4'h1;
		bus(1'b1, OFF_CTL_STATUS, 32'h0);
		byteenable <= 4'hF;
		rdc(OFF_CTL_STATUS, 32'h0B00);
		$display("test control load done");
		tally_and_finish();
	end
endmodule : simd_fp_exception_unit_tb
